// ### shared/hma_consts.svh
`ifndef HMA_CONSTS_SVH
`define HMA_CONSTS_SVH
// Port offsets from the programmed I/O base
`define HMA_OFS_INDEX 16'h0005
`define HMA_OFS_DATA 16'h0006
// Indexed register locations
`define HMA_IDX_CFG 7'h40
`define HMA_IDX_STS1 7'h41
`define HMA_IDX_STS2 7'h42
`define HMA_IDX_MASK1 7'h43
`define HMA_IDX_MASK2 7'h44
`define HMA_IDX_CTL 7'h4c
`define HMA_IDX_RAM_LO 7'h20
`define HMA_IDX_RAM_HI 7'h3f
// Value RAM locations
`define HMA_IDX_VOLT_RD 7'h20
`define HMA_IDX_VOLT_HI 7'h2b
`define HMA_IDX_TEMP1_RD 7'h27
`define HMA_IDX_FAN_RD 7'h28
`define HMA_IDX_TEMP1_OVER 7'h39
`define HMA_IDX_TEMP1_HYST 7'h3a
`define HMA_IDX_FAN_LIM 7'h3b
// Configuration bit positions
`define HMA_CFG_START 0
`define HMA_CFG_IRQ_EN 1
`define HMA_CFG_IRQ_DIS 3
`define HMA_CFG_INIT 7
// Alarm control bit positions
`define HMA_CTL_OVT_POL 2
`define HMA_CTL_OVT2_DIS 3
`define HMA_CTL_OVT3_DIS 4
`define HMA_CTL_T1_ONCE 5
`define HMA_CTL_T23_CMP 6
// Status bit positions
`define HMA_S1_FAN1 6
`define HMA_S1_FAN2 7
`define HMA_S1_T1 4
`define HMA_S1_T2 5
`define HMA_S2_VOLT5 0
`define HMA_S2_FAN3 3
`define HMA_S2_CASE 4
`define HMA_S2_T3 5
`define HMA_S2_TC1 6
`define HMA_S2_TC2 7
`define HMA_S2_RSVD 8'h06
// Reset values
`define HMA_RST_CFG 8'h03
`define HMA_RST_MASK1 8'hfe
`define HMA_RST_MASK2 8'hff
`define HMA_RST_CTL 8'h18
`define HMA_RST_FAN 4'hf
// Hysteresis value that selects comparator mode on the first sensor
`define HMA_HYST_CMP 8'h7f
`endif

// ### shared/hma_pkg.sv
package hma_pkg;
  // Host I/O cycle as seen at the block
  typedef struct packed {
    logic rd;            // One-cycle read strobe
    logic wr;            // One-cycle write strobe
    logic [15:0] addr;   // I/O address
    logic [7:0] wdata;   // Write data
  } hma_io_s;
  // One conversion's worth of readings
  typedef struct packed {
    logic [4:0][7:0] volt;  // Core, a, b, analog supply, c
    logic [2:0][7:0] temp;  // First, second, third sensor
    logic [2:0][7:0] fan;   // Tach counts
  } hma_meas_s;
  // Limits held outside this bank
  typedef struct packed {
    logic [1:0][7:0] over;  // Second and third sensor over-limit
    logic [1:0][7:0] hyst;  // Second and third sensor hysteresis
  } hma_tlim_s;
  // Fan cruise settings per channel
  typedef struct packed {
    logic [2:0] en;          // Cruise mode enable
    logic [2:0][7:0] tgt;    // Target count
    logic [2:0][7:0] tol;    // Tolerance
  } hma_cruise_s;
  // Temperature alarm behaviour
  typedef enum logic [1:0] {
    HMA_T_CMP,
    HMA_T_TWO,
    HMA_T_ONE
  } hma_tmode_e;
endpackage

// ### logic/hma_alarm.sv
`timescale 1ns/1ns
`include "hma_consts.svh"

module hma_alarm (
  input wire logic clk,                      // 250 MHz clock
  input wire logic sys_rst,                  // Synchronous reset, active high
  input wire logic [7:0] base_addr_high,     // I/O base high byte
  input wire logic [7:0] base_addr_low,      // I/O base low byte
  input wire hma_pkg::hma_io_s io_req,       // Host I/O cycle
  output logic [7:0] io_rdata,               // Read data, valid cycle after rd
  input wire logic conv_done,                // Pulse, a conversion finished
  input wire hma_pkg::hma_meas_s meas,       // Readings of that conversion
  input wire hma_pkg::hma_tlim_s tlim,       // Sensor 2-3 limits
  input wire hma_pkg::hma_cruise_s cruise,   // Fan cruise settings
  input wire logic [2:0] ovt_irq_mode,       // Per sensor: 1 latch mode, 0 comparator
  input wire logic [1:0] temp_rd_ext,        // Pulse, sensor 2-3 reading read
  input wire logic [1:0] cruise_timeout,     // Pulse, sensor 1-2 hot at full fan
  input wire logic case_open,                // Pulse, chassis intrusion
  output logic [2:0][3:0] fan_drive_ff,      // First to third fan drive level
  output logic mgmt_irq_out_n,               // Management interrupt, active low
  output logic overtemp_out_n                // Over-temperature, polarity set by control
);

  // Host side registers
  logic [6:0] ptr_ff;             // Index pointer
  logic [7:0] cfg_ff;             // Monitor configuration
  logic [7:0] mask1_ff;           // Interrupt mask one
  logic [7:0] mask2_ff;           // Interrupt mask two
  logic [7:0] ctl_ff;             // Alarm output control
  logic [7:0] sts1_ff;            // Alarm status one
  logic [7:0] sts2_ff;            // Alarm status two
  logic [7:0] ram_ff [32];        // Value RAM
  logic [7:0] nxt_rdata;          // Read mux result
  logic [7:0] set1;               // Status one events
  logic [7:0] set2;               // Status two events
  // Monitor state
  logic [4:0] volt_out_ff;        // Voltage out of window at last conversion
  logic [2:0] fan_out_ff;         // Fan over limit at last conversion
  logic [2:0] hot_ff;             // Temperature in over band
  logic [2:0] ovt_lat_ff;         // Latched over-temperature
  logic [2:0] t_evt;              // Status event per sensor
  logic [2:0] ovt_act;            // Output activity per sensor
  logic [2:0] t_rd;               // Temperature reading read pulses
  logic [15:0] base;              // Programmed base
  logic hit_index;                // Index port addressed
  logic hit_data;                 // Data port addressed
  logic wr_data;                  // Data port write
  logic rd_data;                  // Data port read
  logic run;                      // Monitoring active
  logic init;                     // Restore defaults this cycle
  logic ovt_any;                  // Any over-temperature active, sensors 2-3 only when not disabled
  logic irq_any;                  // Any unmasked status

  // Port decode from the two base bytes
  assign base = {base_addr_high, base_addr_low};
  assign hit_index = (io_req.addr == base + `HMA_OFS_INDEX);
  assign hit_data = (io_req.addr == base + `HMA_OFS_DATA);
  assign wr_data = io_req.wr & hit_data;
  assign rd_data = io_req.rd & hit_data;
  assign init = wr_data & (ptr_ff == `HMA_IDX_CFG) & io_req.wdata[`HMA_CFG_INIT];
  // Conversions count only while started and not disabled
  assign run = cfg_ff[`HMA_CFG_START] & ~cfg_ff[`HMA_CFG_IRQ_DIS];

  // Index pointer, top bit reads zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ptr_ff <= 7'h00;
    end else if (io_req.wr & hit_index) begin
      ptr_ff <= io_req.wdata[6:0];
    end
  end

  // Configuration, masks and control with restore-defaults
  always_ff @(posedge clk) begin
    if (sys_rst | init) begin
      cfg_ff <= `HMA_RST_CFG;
      mask1_ff <= `HMA_RST_MASK1;
      mask2_ff <= `HMA_RST_MASK2;
      ctl_ff <= `HMA_RST_CTL;
    end else if (wr_data) begin
      case (ptr_ff)
        `HMA_IDX_CFG: begin
          cfg_ff <= io_req.wdata & 8'h7f;                         // Init bit never stored
        end
        `HMA_IDX_MASK1: begin
          mask1_ff <= io_req.wdata;
        end
        `HMA_IDX_MASK2: begin
          mask2_ff <= io_req.wdata;
        end
        `HMA_IDX_CTL: begin
          ctl_ff <= io_req.wdata;
        end
        default: begin
          cfg_ff <= cfg_ff;                                       // Other indices leave these
        end
      endcase
    end
  end

  // Value RAM: host writes, readings captured per conversion
  always_ff @(posedge clk) begin
    if (wr_data && ptr_ff >= `HMA_IDX_RAM_LO && ptr_ff <= `HMA_IDX_RAM_HI) begin
      ram_ff[ptr_ff[4:0]] <= io_req.wdata;
    end
    if (conv_done & run) begin
      for (int v = 0; v < 5; v++) begin
        ram_ff[5'(`HMA_IDX_VOLT_RD + 7'(v))] <= meas.volt[v];
      end
      ram_ff[5'(`HMA_IDX_TEMP1_RD)] <= meas.temp[0];
      for (int f = 0; f < 3; f++) begin
        ram_ff[5'(`HMA_IDX_FAN_RD + 7'(f))] <= meas.fan[f];
      end
    end
  end

  // Read mux for both ports
  always_comb begin
    nxt_rdata = 8'h00;
    if (hit_index) begin
      nxt_rdata = {1'b0, ptr_ff};
    end else if (ptr_ff >= `HMA_IDX_RAM_LO && ptr_ff <= `HMA_IDX_RAM_HI) begin
      nxt_rdata = ram_ff[ptr_ff[4:0]];
    end else begin
      case (ptr_ff)
        `HMA_IDX_CFG: nxt_rdata = cfg_ff;
        `HMA_IDX_STS1: nxt_rdata = sts1_ff;
        `HMA_IDX_STS2: nxt_rdata = sts2_ff;
        `HMA_IDX_MASK1: nxt_rdata = mask1_ff;
        `HMA_IDX_MASK2: nxt_rdata = mask2_ff;
        `HMA_IDX_CTL: nxt_rdata = ctl_ff;
        default: nxt_rdata = 8'h00;                               // Unmapped reads zero
      endcase
    end
  end

  // Registered read data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_rdata <= 8'h00;
    end else if (io_req.rd & (hit_index | hit_data)) begin
      io_rdata <= nxt_rdata;
    end
  end

  // Voltage and fan window state at each conversion
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      volt_out_ff <= 5'h00;
      fan_out_ff <= 3'h0;
    end else if (conv_done & run) begin
      for (int v = 0; v < 5; v++) begin
        volt_out_ff[v] <= (meas.volt[v] > ram_ff[5'(`HMA_IDX_VOLT_HI + 7'(2 * v))]) |
                          (meas.volt[v] < ram_ff[5'(`HMA_IDX_VOLT_HI + 7'(2 * v + 1))]);
      end
      for (int f = 0; f < 3; f++) begin
        fan_out_ff[f] <= meas.fan[f] > ram_ff[5'(`HMA_IDX_FAN_LIM + 7'(f))];
      end
    end
  end

  // Temperature reading reads for the latched output
  assign t_rd = {temp_rd_ext, rd_data & (ptr_ff == `HMA_IDX_TEMP1_RD)};

  // Per-sensor temperature alarm and over-temperature output
  for (genvar s = 0; s < 3; s++) begin : g_temp
    logic signed [7:0] t_now;       // Present reading
    logic signed [7:0] t_over;      // Over-limit
    logic signed [7:0] hysteresis_limit;      // Hysteresis limit
    logic above;                    // Above over-limit
    logic nxt_hot;                  // Band state after this conversion
    logic rise;                     // Entered over band
    logic fall;                     // Left over band
    hma_pkg::hma_tmode_e mode;      // Status behaviour
    assign t_now = meas.temp[s];
    if (s == 0) begin : g_first
      assign t_over = ram_ff[5'(`HMA_IDX_TEMP1_OVER)];
      assign hysteresis_limit = ram_ff[5'(`HMA_IDX_TEMP1_HYST)];
      // Hysteresis at 127 forces comparator, else control bit picks
      assign mode = (hysteresis_limit == `HMA_HYST_CMP) ? hma_pkg::HMA_T_CMP :
                    ctl_ff[`HMA_CTL_T1_ONCE] ? hma_pkg::HMA_T_ONE :
                    hma_pkg::HMA_T_TWO;
    end else begin : g_other
      assign t_over = tlim.over[s - 1];
      assign hysteresis_limit = tlim.hyst[s - 1];
      assign mode = ctl_ff[`HMA_CTL_T23_CMP] ? hma_pkg::HMA_T_CMP : hma_pkg::HMA_T_TWO;
    end
    assign above = t_now > t_over;
    assign nxt_hot = above | (hot_ff[s] & ~(t_now < hysteresis_limit));
    assign rise = ~hot_ff[s] & nxt_hot;
    assign fall = hot_ff[s] & ~nxt_hot;

    // Status event per mode, evaluated at conversion end
    always_comb begin
      t_evt[s] = 1'b0;
      if (conv_done & run) begin
        case (mode)
          hma_pkg::HMA_T_CMP: begin
            // First sensor stops below over-limit, others below hysteresis
            t_evt[s] = (s == 0) ? above : nxt_hot;
          end
          hma_pkg::HMA_T_TWO: begin
            t_evt[s] = rise | fall;
          end
          hma_pkg::HMA_T_ONE: begin
            t_evt[s] = rise;
          end
          default: begin
            t_evt[s] = 1'b0;
          end
        endcase
      end
    end

    // Band state and latched output, set wins over read clear
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        hot_ff[s] <= 1'b0;
        ovt_lat_ff[s] <= 1'b0;
      end else begin
        if (conv_done & run) begin
          hot_ff[s] <= nxt_hot;
        end
        if (conv_done & run & (rise | fall)) begin
          ovt_lat_ff[s] <= 1'b1;
        end else if (t_rd[s]) begin
          ovt_lat_ff[s] <= 1'b0;
        end
      end
    end

    // Mode bit picks band-following or latched output
    assign ovt_act[s] = ovt_irq_mode[s] ? ovt_lat_ff[s] : hot_ff[s];
  end

  // Status events: voltage and fan edges, temperatures, extras
  always_comb begin
    set1 = 8'h00;
    set2 = 8'h00;
    if (conv_done & run) begin
      for (int v = 0; v < 4; v++) begin
        set1[v] = volt_out_ff[v] ^ ((meas.volt[v] > ram_ff[5'(`HMA_IDX_VOLT_HI + 7'(2 * v))]) |
                  (meas.volt[v] < ram_ff[5'(`HMA_IDX_VOLT_HI + 7'(2 * v + 1))]));
      end
      set2[`HMA_S2_VOLT5] = volt_out_ff[4] ^ ((meas.volt[4] > ram_ff[5'(`HMA_IDX_VOLT_HI + 7'(8))]) |
                            (meas.volt[4] < ram_ff[5'(`HMA_IDX_VOLT_HI + 7'(9))]));
      set1[`HMA_S1_FAN1] = fan_out_ff[0] ^ (meas.fan[0] > ram_ff[5'(`HMA_IDX_FAN_LIM)]);
      set1[`HMA_S1_FAN2] = fan_out_ff[1] ^ (meas.fan[1] > ram_ff[5'(`HMA_IDX_FAN_LIM + 7'(1))]);
      set2[`HMA_S2_FAN3] = fan_out_ff[2] ^ (meas.fan[2] > ram_ff[5'(`HMA_IDX_FAN_LIM + 7'(2))]);
    end
    set1[`HMA_S1_T1] = t_evt[0];
    set1[`HMA_S1_T2] = t_evt[1];
    set2[`HMA_S2_T3] = t_evt[2];
    set2[`HMA_S2_CASE] = case_open;
    set2[`HMA_S2_TC1] = cruise_timeout[0];
    set2[`HMA_S2_TC2] = cruise_timeout[1];
  end

  // Sticky status, cleared only by reset or by reading it; new events win
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sts1_ff <= 8'h00;
      sts2_ff <= 8'h00;
    end else begin
      sts1_ff <= (rd_data & (ptr_ff == `HMA_IDX_STS1) ? 8'h00 : sts1_ff) | set1;
      sts2_ff <= ((rd_data & (ptr_ff == `HMA_IDX_STS2) ? 8'h00 : sts2_ff) | set2)
                 & ~`HMA_S2_RSVD;
    end
  end

  // Interrupt output from unmasked status
  assign irq_any = |(sts1_ff & ~mask1_ff) | |(sts2_ff & ~mask2_ff);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mgmt_irq_out_n <= 1'b1;
    end else begin
      mgmt_irq_out_n <= ~(cfg_ff[`HMA_CFG_IRQ_EN] & ~cfg_ff[`HMA_CFG_IRQ_DIS] & irq_any);
    end
  end

  // Over-temperature pin with sensor disables and polarity
  assign ovt_any = ovt_act[0] | (ovt_act[1] & ~ctl_ff[`HMA_CTL_OVT2_DIS]) |
                   (ovt_act[2] & ~ctl_ff[`HMA_CTL_OVT3_DIS]);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      overtemp_out_n <= 1'b1;
    end else begin
      overtemp_out_n <= ctl_ff[`HMA_CTL_OVT_POL] ? ovt_any : ~ovt_any;
    end
  end

  // Fan speed cruise: step drive one level per conversion
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int f = 0; f < 3; f++) begin
        fan_drive_ff[f] <= `HMA_RST_FAN;                            // Full speed at start
      end
    end else if (conv_done & run) begin
      for (int f = 0; f < 3; f++) begin
        if (cruise.en[f]) begin
          if ({1'b0, meas.fan[f]} > {1'b0, cruise.tgt[f]} + {1'b0, cruise.tol[f]} &&
              fan_drive_ff[f] != 4'hf) begin
            fan_drive_ff[f] <= fan_drive_ff[f] + 4'h1;
          end else if ({1'b0, meas.fan[f]} + {1'b0, cruise.tol[f]} < {1'b0, cruise.tgt[f]} &&
                       fan_drive_ff[f] != 4'h0) begin
            fan_drive_ff[f] <= fan_drive_ff[f] - 4'h1;
          end
        end
      end
    end
  end

endmodule // hma_alarm

// ### verification/hma_alarm_asserts.sv
`timescale 1ns/1ns
`include "hma_consts.svh"

// Port-level timing checks of the alarm bank
module hma_alarm_asserts (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset, active high
  input wire logic [7:0] base_addr_high, // Base high byte
  input wire logic [7:0] base_addr_low, // Base low byte
  input wire hma_pkg::hma_io_s io_req, // Host cycle
  input wire logic [7:0] io_rdata, // Read data
  input wire logic conv_done, // Conversion pulse
  input wire hma_pkg::hma_meas_s meas, // Readings
  input wire hma_pkg::hma_cruise_s cruise, // Cruise settings
  input wire logic [1:0] temp_rd_ext, // Sensor 2-3 read pulses
  input wire logic [1:0] cruise_timeout, // Full fan events
  input wire logic case_open, // Intrusion pulse
  input wire logic [2:0][3:0] fan_drive_ff, // Drive levels
  input wire logic mgmt_irq_out_n, // Interrupt pin
  input wire logic overtemp_out_n // Over-temperature pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Decoded ports
  wire logic [15:0] idx_port = {base_addr_high, base_addr_low} + `HMA_OFS_INDEX;
  wire logic [15:0] dat_port = {base_addr_high, base_addr_low} + `HMA_OFS_DATA;
  // Channel 0 band edges, widened so the sums cannot wrap
  wire logic [8:0] band_hi = {1'b0, cruise.tgt[0]} + {1'b0, cruise.tol[0]};
  wire logic [8:0] cnt_lo = {1'b0, meas.fan[0]} + {1'b0, cruise.tol[0]};
  wire logic above = conv_done && cruise.en[0] && ({1'b0, meas.fan[0]} > band_hi);
  wire logic below = conv_done && cruise.en[0] && (cnt_lo < {1'b0, cruise.tgt[0]});
  // Causes that may move the pins
  wire logic host = io_req.rd || io_req.wr;
  wire logic wake = conv_done || (|cruise_timeout) || case_open || io_req.wr;
  wire logic ovt_cause = conv_done || host || (|temp_rd_ext);

  rst_quiet_a: assert property (disable iff (1'b0) sys_rst |=> mgmt_irq_out_n && overtemp_out_n
    && io_rdata == 8'h00 && fan_drive_ff == {3{4'hf}}) else $error("outputs not at rest after reset");
  rdata_hold_a: assert property (!io_req.rd |=> $stable(io_rdata))
    else $error("read data moved without a read");
  bad_addr_a: assert property (io_req.rd && io_req.addr != idx_port && io_req.addr != dat_port
    |=> $stable(io_rdata)) else $error("foreign address answered");
  ptr_top_a: assert property (io_req.rd && io_req.addr == idx_port |=> !io_rdata[7])
    else $error("pointer top bit read as one");
  cruise_up_a: assert property (above |=> fan_drive_ff[0] >= $past(fan_drive_ff[0]))
    else $error("drive fell while count above band");
  cruise_down_a: assert property (below |=> fan_drive_ff[0] <= $past(fan_drive_ff[0]))
    else $error("drive rose while count below band");
  band_hold_a: assert property (conv_done && cruise.en[0] && !above && !below
    |=> $stable(fan_drive_ff[0])) else $error("drive moved inside band");
  drive_idle_a: assert property (!conv_done |=> $stable(fan_drive_ff))
    else $error("drive moved without conversion");
  irq_fall_a: assert property ($fell(mgmt_irq_out_n) |-> $past(wake) || $past(wake, 2))
    else $error("interrupt asserted without cause");
  irq_rise_a: assert property ($rose(mgmt_irq_out_n) |-> $past(host) || $past(host, 2))
    else $error("interrupt released without host access");
  ovt_move_a: assert property ($changed(overtemp_out_n) |-> $past(ovt_cause) || $past(ovt_cause, 2))
    else $error("over-temperature pin moved without cause");
endmodule // hma_alarm_asserts

bind hma_alarm hma_alarm_asserts hma_alarm_asserts_inst (.clk, .sys_rst, .base_addr_high, .base_addr_low,
  .io_req, .io_rdata, .conv_done, .meas, .cruise, .temp_rd_ext, .cruise_timeout, .case_open, .fan_drive_ff,
  .mgmt_irq_out_n, .overtemp_out_n);

// ### verification/hma_alarm_tb.sv
`timescale 1ns/1ns
`include "hma_consts.svh"

// Self-checking bench with a behavioural alarm model
module hma_alarm_tb;
  localparam logic [7:0] VHI = 8'h80; // Voltage 0 high limit
  localparam logic [7:0] VLO = 8'h40; // Voltage 0 low limit
  localparam logic [7:0] TOV = 8'h50; // Sensor 1 over-limit
  localparam logic [7:0] FLIM = 8'hc8; // Fan 0 count limit
  logic clk = 1'b0; // Clock
  logic sys_rst = 1'b1; // Reset
  logic [7:0] base_addr_high = 8'h00; // Base high
  logic [7:0] base_addr_low = 8'h00; // Base low
  hma_pkg::hma_io_s io_req = '0; // Host cycle
  logic conv_done = 1'b0; // Conversion pulse
  hma_pkg::hma_meas_s meas = '0; // Readings
  hma_pkg::hma_tlim_s tlim = {8'h50, 8'h50, 8'h40, 8'h40}; // Sensor 2-3 limits, fixed
  hma_pkg::hma_cruise_s cruise = '0; // Cruise settings
  logic [2:0] ovt_irq_mode = 3'h0; // Pin mode per sensor
  logic [1:0] temp_rd_ext = 2'h0; // Fixed low
  logic [1:0] cruise_timeout = 2'h0; // Full fan events
  logic case_open = 1'b0; // Intrusion
  logic [7:0] io_rdata; // Read data
  logic [2:0][3:0] fan_drive_ff; // Drives
  logic mgmt_irq_out_n; // Interrupt
  logic overtemp_out_n; // Over-temperature
  integer seed = 32'h9e71; // Random seed
  integer bad_count = 0; // Mismatches
  integer checked = 0; // Comparisons
  integer drv = 15; // Model drive, channel 0
  logic [15:0] base; // Programmed base
  logic [7:0] m_cfg, m_msk1, m_msk2, m_ctl, m_s1, m_s2, m_hyst, vr; // Model registers, random reading
  logic vout = 1'b0, fout = 1'b0, hot = 1'b0, lat = 1'b0; // Model alarm state
  logic [6:0] rst_idx [6] = '{`HMA_IDX_CFG, `HMA_IDX_STS1, `HMA_IDX_STS2, `HMA_IDX_MASK1, `HMA_IDX_MASK2, `HMA_IDX_CTL};
  logic [7:0] rst_val [6] = '{`HMA_RST_CFG, 8'h00, 8'h00, `HMA_RST_MASK1, `HMA_RST_MASK2, `HMA_RST_CTL};
  logic [7:0] tseq [5] = '{8'h20, 8'h60, 8'h60, 8'h48, 8'h20}; // Cold, hot, hot, band, cold
  logic [7:0] fseq [7] = '{8'h64, 8'h64, 8'h64, 8'ha0, 8'haa, 8'h96, 8'hb4}; // Below, edges, above

  always #2 clk = ~clk;

  hma_alarm hma_alarm_inst (.clk, .sys_rst, .base_addr_high, .base_addr_low, .io_req, .io_rdata, .conv_done,
    .meas, .tlim, .cruise, .ovt_irq_mode, .temp_rd_ext, .cruise_timeout, .case_open, .fan_drive_ff,
    .mgmt_irq_out_n, .overtemp_out_n);

  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One host cycle, strobe held for one edge
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    io_req <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk);
    io_req.rd <= 1'b0;
    io_req.wr <= 1'b0;
    #1;
  endtask

  // Indexed write, model follows
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    io(1'b1, base + `HMA_OFS_INDEX, {1'b0, idx});
    io(1'b1, base + `HMA_OFS_DATA, d);
    case (idx)
      `HMA_IDX_CFG: begin
        m_cfg = d[`HMA_CFG_INIT] ? `HMA_RST_CFG : d;
        if (d[`HMA_CFG_INIT]) {m_msk1, m_msk2, m_ctl} = {`HMA_RST_MASK1, `HMA_RST_MASK2, `HMA_RST_CTL};
      end
      `HMA_IDX_MASK1: m_msk1 = d;
      `HMA_IDX_MASK2: m_msk2 = d;
      `HMA_IDX_CTL: m_ctl = d;
      `HMA_IDX_TEMP1_HYST: m_hyst = d;
      default: ;
    endcase
  endtask

  // Indexed read and compare; reads clear what they should
  task automatic rdchk(input logic [6:0] idx, input logic [7:0] exp);
    io(1'b1, base + `HMA_OFS_INDEX, {1'b0, idx});
    io(1'b0, base + `HMA_OFS_DATA, 8'h00);
    chk(io_rdata, exp);
    if (idx == `HMA_IDX_STS1) m_s1 = 8'h00;
    if (idx == `HMA_IDX_STS2) m_s2 = 8'h00;
    if (idx == `HMA_IDX_TEMP1_RD) lat = 1'b0;
  endtask

  // Pins one cycle after the cause
  task automatic pins;
    logic act;
    logic irq_n;
    @(posedge clk);
    #1;
    act = ovt_irq_mode[0] ? lat : hot;
    irq_n = !(m_cfg[`HMA_CFG_IRQ_EN] && !m_cfg[`HMA_CFG_IRQ_DIS] && |((m_s1 & ~m_msk1) | (m_s2 & ~m_msk2)));
    chk({7'h0, mgmt_irq_out_n}, {7'h0, irq_n});
    chk({7'h0, overtemp_out_n}, {7'h0, m_ctl[`HMA_CTL_OVT_POL] ? act : !act});
    chk({4'h0, fan_drive_ff[0]}, drv[7:0]);
  endtask

  // One conversion through design and model
  task automatic conv(input logic [7:0] v0, input logic [7:0] t1, input logic [7:0] f0);
    logic h;
    @(posedge clk);
    meas.volt[0] <= v0;
    meas.temp[0] <= t1;
    meas.fan[0] <= f0;
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    if (m_cfg[`HMA_CFG_START] && !m_cfg[`HMA_CFG_IRQ_DIS]) begin // Monitoring running
      if (((v0 > VHI) || (v0 < VLO)) != vout) m_s1[0] = 1'b1;
      vout = (v0 > VHI) || (v0 < VLO);
      if ((f0 > FLIM) != fout) m_s1[`HMA_S1_FAN1] = 1'b1;
      fout = f0 > FLIM;
      h = ($signed(t1) > $signed(TOV)) ? 1'b1 : ($signed(t1) < $signed(m_hyst)) ? 1'b0 : hot;
      if (m_hyst == `HMA_HYST_CMP) begin // Comparator: every hot conversion
        if ($signed(t1) > $signed(TOV)) m_s1[`HMA_S1_T1] = 1'b1;
      end else if (m_ctl[`HMA_CTL_T1_ONCE]) begin // One-time: rise only
        if (h && !hot) m_s1[`HMA_S1_T1] = 1'b1;
      end else if (h != hot) m_s1[`HMA_S1_T1] = 1'b1; // Two-times: rise and fall
      if (ovt_irq_mode[0] && (h != hot)) lat = 1'b1;
      hot = h;
      if (cruise.en[0] && ({1'b0, f0} > cruise.tgt[0] + cruise.tol[0])) drv = (drv < 15) ? drv + 1 : 15;
      else if (cruise.en[0] && ({1'b0, f0} + cruise.tol[0] < cruise.tgt[0])) drv = (drv > 0) ? drv - 1 : 0;
    end
    pins;
  endtask

  // Hang guard
  initial begin
    #100000;
    bad_count++;
    wrap_up;
  end

  // Main sequence
  initial begin
    meas.volt = {5{8'h60}};
    meas.temp = {8'h80, 8'h80, 8'h00};
    meas.fan = {3{8'h10}};
    base = 16'($random(seed));
    base_addr_high <= base[15:8];
    base_addr_low <= base[7:0];
    {m_cfg, m_msk1, m_msk2, m_ctl} = {`HMA_RST_CFG, `HMA_RST_MASK1, `HMA_RST_MASK2, `HMA_RST_CTL};
    {m_s1, m_s2, m_hyst} = {8'h00, 8'h00, 8'h40};
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    pins;
    for (int i = 0; i < 6; i++) rdchk(rst_idx[i], rst_val[i]);
    io(1'b1, base + `HMA_OFS_INDEX, 8'hc5);
    io(1'b0, base + `HMA_OFS_INDEX, 8'h00);
    chk(io_rdata, 8'h45);
    io(1'b0, base + 16'h0007, 8'h00);
    chk(io_rdata, 8'h45);
    io(1'b0, base + `HMA_OFS_DATA, 8'h00);
    chk(io_rdata, 8'h00);
    for (int i = 0; i < 10; i++) wr(`HMA_IDX_VOLT_HI + 7'(i), i[0] ? 8'h00 : 8'hff);
    wr(`HMA_IDX_VOLT_HI, VHI);
    wr(`HMA_IDX_VOLT_HI + 7'h1, VLO);
    wr(`HMA_IDX_TEMP1_OVER, TOV);
    wr(`HMA_IDX_TEMP1_HYST, 8'h40);
    wr(`HMA_IDX_FAN_LIM, FLIM);
    wr(`HMA_IDX_FAN_LIM + 7'h1, 8'hff);
    wr(`HMA_IDX_FAN_LIM + 7'h2, 8'hff);
    wr(`HMA_IDX_MASK1, 8'h00);
    wr(`HMA_IDX_MASK2, 8'h00);
    rdchk(`HMA_IDX_MASK1, 8'h00);
    vr = {3'b010, 5'($random(seed))};
    conv(8'h90, 8'h00, 8'h10);
    wr(`HMA_IDX_CFG, 8'h02);
    pins;
    conv(vr, 8'h00, 8'h10);
    wr(`HMA_IDX_CFG, 8'h0b);
    pins;
    conv(vr, 8'h00, 8'h10);
    wr(`HMA_IDX_CFG, 8'h03);
    pins;
    wr(`HMA_IDX_MASK1, 8'h01);
    pins;
    wr(`HMA_IDX_MASK1, 8'h00);
    rdchk(`HMA_IDX_STS1, m_s1);
    pins;
    conv(8'h90, 8'h00, 8'h10);
    conv(vr, 8'h00, 8'h10);
    rdchk(`HMA_IDX_STS1, m_s1);
    conv(vr, 8'h00, 8'he0);
    rdchk(`HMA_IDX_STS1, m_s1);
    conv(vr, 8'h00, 8'h10);
    rdchk(`HMA_IDX_STS1, m_s1);
    @(posedge clk);
    case_open <= 1'b1;
    cruise_timeout <= 2'b11;
    @(posedge clk);
    case_open <= 1'b0;
    cruise_timeout <= 2'b00;
    m_s2 = 8'hd0;
    pins;
    rdchk(`HMA_IDX_STS2, m_s2);
    rdchk(`HMA_IDX_STS2, m_s2);
    for (int m = 0; m < 3; m++) begin // Comparator, two-times, one-time
      wr(`HMA_IDX_TEMP1_HYST, (m == 0) ? `HMA_HYST_CMP : 8'h40);
      wr(`HMA_IDX_CTL, (m == 2) ? 8'h38 : (m == 1) ? 8'h1c : 8'h18);
      if (m == 2) begin // Latched pin from a clean latch
        rdchk(`HMA_IDX_TEMP1_RD, 8'h20);
        @(posedge clk);
        ovt_irq_mode <= 3'b001;
      end
      for (int k = 0; k < 5; k++) begin
        vr = {3'b010, 5'($random(seed))};
        conv(vr, tseq[k], 8'h10);
        rdchk(`HMA_IDX_STS1, m_s1);
        rdchk(`HMA_IDX_TEMP1_RD, tseq[k]);
      end
    end
    @(posedge clk);
    cruise <= '{en: 3'b001, tgt: 24'h0000a0, tol: 24'h00000a};
    for (int k = 0; k < 7; k++) conv(vr, 8'h20, fseq[k]);
    // Sensor 2 comparator keeps flagging until below its hysteresis
    wr(`HMA_IDX_CTL, 8'h58);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      meas.temp[1] <= (k < 2) ? 8'h60 : (k == 2) ? 8'h48 : 8'h20;
      m_s1[`HMA_S1_T2] = (k < 3);
      conv(vr, 8'h20, 8'hb4);
      rdchk(`HMA_IDX_STS1, m_s1);
    end
    wr(`HMA_IDX_CFG, 8'h80);
    for (int i = 0; i < 6; i++) rdchk(rst_idx[i], rst_val[i]);
    wrap_up;
  end
endmodule // hma_alarm_tb
